// ### rtl/oap_pkg.sv
// shared constants and carrier types for the observation and alarm panel controller
package oap_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OAP_CTRL_OFS   = 8'h00;
  localparam logic [7:0] OAP_PERIOD_OFS = 8'h04;
  localparam logic [7:0] OAP_ADDR_OFS   = 8'h08;
  localparam logic [7:0] OAP_SEL_OFS    = 8'h0c;
  localparam logic [7:0] OAP_STATUS_OFS = 8'h10;
  localparam logic [7:0] OAP_STORED_OFS = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OAP_CTRL_START  = 0;  // write 1: start observation
  localparam int OAP_CTRL_STOP   = 1;  // write 1: end observation
  localparam int OAP_CTRL_TEST   = 2;  // level: test requested
  localparam int OAP_CTRL_PAR_A  = 3;  // write 1: archive parity report, bit a
  localparam int OAP_CTRL_PAR_B  = 4;  // write 1: archive parity report, bit b
  localparam int OAP_SEL_A_LSB   = 0;
  localparam int OAP_SEL_B_LSB   = 4;
  localparam int OAP_SEL_C_LSB   = 8;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [15:0] OAP_PERIOD_RST = 16'h000a; // base ticks per dump interval
  localparam logic [3:0]  OAP_PHASE_CYC  = 4'h4;     // cycles per sequencer phase
  localparam logic [15:0] OAP_SELF_LO    = 16'h0100; // self-count lower limit
  localparam logic [15:0] OAP_SELF_HI    = 16'hff00; // self-count upper limit

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OAP_SEQ_IDLE  = 3'b000,
    OAP_SEQ_WRITE = 3'b001,
    OAP_SEQ_CHECK = 3'b010,
    OAP_SEQ_SUB   = 3'b011,
    OAP_SEQ_READ  = 3'b100,
    OAP_SEQ_SEND  = 3'b101
  } oap_seq_type;

  // front panel pushbuttons and switches, levels, high = pressed or on
  typedef struct packed {
    logic       interlock;
    logic       fr_startup;
    logic       fr_left;
    logic       fr_right;
    logic       fr_self;
    logic       fr_osc;
    logic       ind_test;
    logic       alarm_reset;
    logic [3:0] ind_reset;      // overflow, parity ts, parity archive, terminal
    logic       monitor_override;
    logic       local_test;
    logic       disp_par_sw1;
    logic       term_src_sw;
    logic       clock_sw_test;  // any clock-board switch in a test position
  } oap_panel_type;

  // error events and conditions from the rest of the controller
  typedef struct packed {
    logic left_fail;
    logic right_fail;
    logic overflow;
    logic parity_ts;
    logic term_err;
    logic osc_fail;
  } oap_event_type;

  // error indicator latches
  typedef struct packed {
    logic left_pf;
    logic right_pf;
    logic self_cnt;
    logic overflow;
    logic parity_ts;
    logic parity_arch;
    logic terminal;
  } oap_err_type;

  // panel lamps other than the test-point selector leds
  typedef struct packed {
    logic         disp_super;
    logic         disp_test;
    logic         visual;
    logic         clock_test;
    logic         osc_standby;
    oap_err_type  err;
  } oap_lamp_type;

endpackage : oap_pkg

// ### rtl/oap_ctrl.sv
// observation sequencing, alarm latches and panel control with an apb register port
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module oap_ctrl
  import oap_pkg::*;
#(
  parameter int SEL_C_N = 80
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire oap_panel_type       panel,
  input  wire oap_event_type       evt,
  input  wire logic                base_tick,
  input  wire logic [15:0]         self_count,
  input  wire logic                term_word_valid,
  input  wire logic                diag_active,
  input  wire logic [7:0]          sig_a,
  input  wire logic [7:0]          sig_b,
  input  wire logic [SEL_C_N-1:0]  sig_c,
  output var  oap_lamp_type        lamps,
  output var  logic                buzzer,
  output logic                     super_clk_en,
  output logic                     term_word_accept,
  output logic                     term_seq_reset,
  output logic                     term_to_ctrl,
  output logic                     term_monitor,
  output logic                     par_disp_en,
  output logic                     dump_pulse,
  output logic                     delay_send,
  output logic                     pf_check,
  output oap_seq_type              seq_phase,
  output logic                     master_reset,
  output var  logic                tp_a,
  output var  logic                tp_b,
  output var  logic                tp_c
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OAP_CTRL_OFS) || (a == OAP_PERIOD_OFS) || (a == OAP_ADDR_OFS) ||
             (a == OAP_SEL_OFS) || (a == OAP_STATUS_OFS) || (a == OAP_STORED_OFS);
  endfunction : mapped

  logic        wr_ok;
  logic [15:0] period_reg;
  logic [31:0] addr_reg;
  logic [31:0] stored_reg;
  logic [15:0] sel_reg;
  logic        test_reg;
  logic        observing_reg;
  oap_err_type err_reg;
  logic        buzzer_reg;
  logic        osc_standby_reg;
  logic [15:0] tick_cnt_reg;
  oap_seq_type seq_reg;
  logic [3:0]  phase_cnt_reg;
  logic        obs_start;
  logic        obs_stop;
  logic        arch_par;
  logic        su;
  logic [6:0]  err_set;

  // zero wait: read data is captured in the setup cycle, write data and the answer in the access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign wr_ok   = psel & penable & pwrite & mapped(paddr);

  // start-up master reset, gated by the interlock
  // interlock gating
  assign su           = panel.interlock & panel.fr_startup;
  assign master_reset = su;

  // clock test switches block a start; while observing the lamp is lit only by the lamp test
  assign obs_start = wr_ok & (paddr == OAP_CTRL_OFS) & pwdata[OAP_CTRL_START] &
                     ~panel.clock_sw_test;
  assign obs_stop  = wr_ok & (paddr == OAP_CTRL_OFS) & pwdata[OAP_CTRL_STOP];
  assign arch_par  = wr_ok & (paddr == OAP_CTRL_OFS) &
                     (pwdata[OAP_CTRL_PAR_A] | pwdata[OAP_CTRL_PAR_B]);

  // read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        OAP_CTRL_OFS:   prdata <= {29'h0, test_reg, 2'h0};
        OAP_PERIOD_OFS: prdata <= {16'h0, period_reg};
        OAP_ADDR_OFS:   prdata <= addr_reg;
        OAP_SEL_OFS:    prdata <= {16'h0, sel_reg};
        OAP_STATUS_OFS: prdata <= {18'h0, seq_reg, osc_standby_reg, panel.clock_sw_test,
                                   buzzer_reg, observing_reg, err_reg};
        OAP_STORED_OFS: prdata <= stored_reg;
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // configuration registers, not touched by the start-up reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_reg <= OAP_PERIOD_RST;
      addr_reg   <= 32'h0000_0000;
      sel_reg    <= 16'h0000;
      test_reg   <= 1'b0;
    end else if (wr_ok) begin
      unique case (paddr)
        OAP_PERIOD_OFS: period_reg <= pwdata[15:0];
        OAP_ADDR_OFS:   addr_reg   <= pwdata;
        OAP_SEL_OFS:    sel_reg    <= pwdata[15:0];
        OAP_CTRL_OFS:   test_reg   <= pwdata[OAP_CTRL_TEST];
        default:        test_reg   <= test_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // observation state and dump interval generator
  // ----------------------------------------------------------------
  // start actions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      observing_reg <= 1'b0;
      stored_reg    <= 32'h0000_0000;
    end else if (su) begin
      observing_reg <= 1'b0;
    end else if (obs_start) begin
      observing_reg <= 1'b1;
      stored_reg    <= addr_reg;
    end else if (obs_stop) begin
      observing_reg <= 1'b0;
    end
  end

  // generator reloads at start; a forced dump marks the first interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 16'h0000;
      dump_pulse   <= 1'b0;
    end else if (su) begin
      tick_cnt_reg <= 16'h0000;
      dump_pulse   <= 1'b0;
    end else if (obs_start) begin
      tick_cnt_reg <= 16'h0000;
      dump_pulse   <= 1'b1;
    end else if (observing_reg && base_tick) begin
      // a period of zero is treated as one tick
      if (tick_cnt_reg + 16'h0001 >= period_reg) begin
        tick_cnt_reg <= 16'h0000;
        dump_pulse   <= 1'b1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 16'h0001;
        dump_pulse   <= 1'b0;
      end
    end else begin
      dump_pulse <= 1'b0;
    end
  end

  assign delay_send = dump_pulse & observing_reg;
  assign pf_check   = dump_pulse & observing_reg;

  // ----------------------------------------------------------------
  // main sequencer: one pass per dump interval
  // ----------------------------------------------------------------
  // sequencer phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg       <= OAP_SEQ_IDLE;
      phase_cnt_reg <= 4'h0;
    end else if (su || !observing_reg) begin
      seq_reg       <= OAP_SEQ_IDLE;
      phase_cnt_reg <= 4'h0;
    end else if (seq_reg == OAP_SEQ_IDLE) begin
      if (dump_pulse) begin
        seq_reg       <= OAP_SEQ_WRITE;
        phase_cnt_reg <= 4'h0;
      end
    end else if (phase_cnt_reg == OAP_PHASE_CYC - 4'h1) begin
      phase_cnt_reg <= 4'h0;
      unique case (seq_reg)
        OAP_SEQ_WRITE: seq_reg <= OAP_SEQ_CHECK;
        OAP_SEQ_CHECK: seq_reg <= OAP_SEQ_SUB;
        OAP_SEQ_SUB:   seq_reg <= OAP_SEQ_READ;
        OAP_SEQ_READ:  seq_reg <= OAP_SEQ_SEND;
        default:       seq_reg <= OAP_SEQ_IDLE;
      endcase
    end else begin
      phase_cnt_reg <= phase_cnt_reg + 4'h1;
    end
  end
  assign seq_phase = seq_reg;

  // ----------------------------------------------------------------
  // error indicator latches
  // ----------------------------------------------------------------
  // set terms: left, right, self, overflow, parity ts, parity archive, terminal
  // event sources
  assign err_set = {evt.left_fail & pf_check, evt.right_fail & pf_check,
                    (seq_reg == OAP_SEQ_CHECK) && (phase_cnt_reg == 4'h0) &&
                    ((self_count < OAP_SELF_LO) || (self_count > OAP_SELF_HI)),
                    evt.overflow, evt.parity_ts & (seq_reg == OAP_SEQ_WRITE),
                    arch_par, evt.term_err};

  // latches hold; sets win over every clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= '0;
    end else begin
      err_reg.left_pf     <= err_set[6] |
                             (err_reg.left_pf & ~su & ~obs_start &
                              ~(panel.interlock & panel.fr_left));
      err_reg.right_pf    <= err_set[5] |
                             (err_reg.right_pf & ~su & ~obs_start &
                              ~(panel.interlock & panel.fr_right));
      err_reg.self_cnt    <= err_set[4] |
                             (err_reg.self_cnt & ~su & ~obs_start &
                              ~(panel.interlock & panel.fr_self));
      err_reg.overflow    <= err_set[3] |
                             (err_reg.overflow & ~su & ~obs_start &
                              ~(panel.ind_reset[3] & ~evt.overflow));
      err_reg.parity_ts   <= err_set[2] |
                             (err_reg.parity_ts & ~su & ~obs_start &
                              ~(panel.ind_reset[2] & ~evt.parity_ts));
      err_reg.parity_arch <= err_set[1] |
                             (err_reg.parity_arch & ~su & ~obs_start & ~panel.ind_reset[1]);
      err_reg.terminal    <= err_set[0] |
                             (err_reg.terminal & ~su & ~(panel.ind_reset[0] & ~evt.term_err));
    end
  end

  // buzzer on new error; alarm reset silences
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buzzer_reg <= 1'b0;
    end else if (|(err_set & ~err_reg)) begin
      buzzer_reg <= 1'b1;
    end else if (panel.alarm_reset || su) begin
      buzzer_reg <= 1'b0;
    end
  end

  // oscillator return; a failure switches to standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_standby_reg <= 1'b0;
    end else if (evt.osc_fail) begin
      osc_standby_reg <= 1'b1;
    end else if (panel.interlock && panel.fr_osc) begin
      osc_standby_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // panel outputs
  // ----------------------------------------------------------------
  // visual alarm and clock gate; status; lamp test
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamps  <= '0;
      buzzer <= 1'b0;
    end else begin
      lamps.disp_super  <= observing_reg | panel.ind_test;
      lamps.disp_test   <= (test_reg & ~observing_reg) | panel.ind_test;
      lamps.visual      <= (|err_reg) | panel.monitor_override | panel.local_test |
                           panel.ind_test;
      lamps.clock_test  <= (panel.clock_sw_test & ~observing_reg) | panel.ind_test;
      lamps.osc_standby <= osc_standby_reg | panel.ind_test;
      lamps.err         <= err_reg | {7{panel.ind_test}};
      buzzer            <= buzzer_reg | panel.ind_test;
    end
  end
  assign super_clk_en = ~panel.local_test;

  // terminal lockout; entry sequencer reset at start
  assign term_word_accept = term_word_valid & ~observing_reg;
  assign term_seq_reset   = obs_start | su;

  // diagnostic traffic overrides the source switch
  assign term_to_ctrl = diag_active | panel.term_src_sw;
  assign term_monitor = diag_active;

  assign par_disp_en = ~observing_reg & panel.disp_par_sw1 & panel.local_test;

  // test point selectors, never forced by the lamp test
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tp_a <= 1'b0;
      tp_b <= 1'b0;
      tp_c <= 1'b0;
    end else begin
      tp_a <= sig_a[sel_reg[OAP_SEL_A_LSB +: 3]];
      tp_b <= sig_b[sel_reg[OAP_SEL_B_LSB +: 3]];
      tp_c <= (int'(sel_reg[OAP_SEL_C_LSB +: 7]) < SEL_C_N) ?
              sig_c[sel_reg[OAP_SEL_C_LSB +: 7]] : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_start_lights;
    @(posedge pclk) disable iff (!presetn)
      obs_start && !su |-> ##1 observing_reg ##1 lamps.disp_super;
  endproperty
  a_start_lights: assert property (p_start_lights) else $error("start did not light display");

  property p_forced_dump;
    @(posedge pclk) disable iff (!presetn)
      obs_start && !su |=> dump_pulse && delay_send && pf_check;
  endproperty
  a_forced_dump: assert property (p_forced_dump) else $error("no forced dump at start");

  property p_seq_start;
    @(posedge pclk) disable iff (!presetn)
      seq_reg == OAP_SEQ_IDLE && dump_pulse && observing_reg && !su
      |=> seq_reg == OAP_SEQ_WRITE ##4 seq_reg == OAP_SEQ_CHECK;
  endproperty
  a_seq_start: assert property (p_seq_start) else $error("sequencer order wrong");

  property p_lockout;
    @(posedge pclk) disable iff (!presetn)
      observing_reg |-> !term_word_accept;
  endproperty
  a_lockout: assert property (p_lockout) else $error("terminal entry taken while observing");

  property p_buzz_on_err;
    @(posedge pclk) disable iff (!presetn)
      $rose(err_reg.overflow) |-> buzzer_reg ##1 buzzer;
  endproperty
  a_buzz_on_err: assert property (p_buzz_on_err) else $error("buzzer silent on new error");

  property p_interlock;
    @(posedge pclk) disable iff (!presetn)
      err_reg.left_pf && !panel.interlock && !obs_start |=> err_reg.left_pf;
  endproperty
  a_interlock: assert property (p_interlock) else $error("reset acted without interlock");

  property p_ind_reset_hold;
    @(posedge pclk) disable iff (!presetn)
      err_reg.overflow && evt.overflow |=> err_reg.overflow;
  endproperty
  a_ind_reset_hold: assert property (p_ind_reset_hold) else $error("overflow cleared too early");

  property p_arch_par;
    @(posedge pclk) disable iff (!presetn)
      arch_par |=> err_reg.parity_arch ##1 lamps.err.parity_arch;
  endproperty
  a_arch_par: assert property (p_arch_par) else $error("archive parity not latched");

  property p_clock_lamp;
    @(posedge pclk) disable iff (!presetn)
      observing_reg && $past(observing_reg) && !panel.ind_test && !$past(panel.ind_test)
      |-> !lamps.clock_test;
  endproperty
  a_clock_lamp: assert property (p_clock_lamp) else $error("clock test lamp lit while observing");

  property p_par_disp;
    @(posedge pclk) disable iff (!presetn)
      par_disp_en |-> !observing_reg && panel.local_test;
  endproperty
  a_par_disp: assert property (p_par_disp) else $error("parity display enabled wrongly");

endmodule : oap_ctrl

`default_nettype wire

// ### dv/oap_super_model.sv
// supervising computer model: apb master and base tick source
`timescale 1ns/1ps
`default_nettype none
module oap_super_model
  import oap_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic             base_tick
);
  logic [31:0] rd_val;
  logic        rd_err;
  logic [1:0]  tick_cnt;
  event        rd_ev;
  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, base_tick, tick_cnt} = '0;
  end
  // request held until pready is seen high, so a slow slave is safe too
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_val = prdata;
    rd_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (!wr) -> rd_ev;
  endtask : xfer
  task automatic report_par(input int b);
    xfer(1'b1, OAP_CTRL_OFS, 32'h1 << (OAP_CTRL_PAR_A + b));
  endtask : report_par
  // time base: one tick every fourth cycle
  always @(posedge pclk) begin
    tick_cnt  <= tick_cnt + 2'd1;
    base_tick <= (tick_cnt == 2'd3);
  end
endmodule : oap_super_model
`default_nettype wire

// ### dv/oap_ctrl_tb.sv
// self-checking bench for the observation and alarm panel controller
`timescale 1ns/1ps
`default_nettype none
module oap_ctrl_tb;
  import oap_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, base_tick;
  logic          buzzer, super_clk_en, term_word_accept, term_seq_reset, term_to_ctrl;
  logic          term_monitor, par_disp_en, dump_pulse, delay_send, pf_check;
  logic          master_reset, tp_a, tp_b, tp_c, term_word_valid, diag_active;
  logic [7:0]    paddr, sig_a, sig_b;
  logic [31:0]   pwdata, prdata;
  logic [15:0]   self_count;
  logic [79:0]   sig_c;
  logic [6:0]    c;
  oap_panel_type pn;
  oap_event_type ev;
  oap_lamp_type  lamps;
  oap_seq_type   seq_phase;
  logic [31:0]   exp_q[$];
  int            failures, compares, cyc, seed;
  oap_ctrl #(.SEL_C_N(80)) oap_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .panel(pn), .evt(ev), .base_tick,
    .self_count, .term_word_valid, .diag_active, .sig_a, .sig_b, .sig_c, .lamps,
    .buzzer, .super_clk_en, .term_word_accept, .term_seq_reset, .term_to_ctrl,
    .term_monitor, .par_disp_en, .dump_pulse, .delay_send, .pf_check, .seq_phase,
    .master_reset, .tp_a, .tp_b, .tp_c);
  oap_super_model oap_super_model_i (.pclk, .pready, .pslverr, .prdata, .psel,
    .penable, .pwrite, .paddr, .pwdata, .base_tick);
  // ------------------------------------------------------------
  // clock, watchers, helpers
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // settle on the falling edge so registered outputs have landed
  task automatic sk(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : sk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    oap_super_model_i.xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge pclk);
    oap_super_model_i.xfer(1'b0, a, 32'h0);
  endtask : rd
  always @(oap_super_model_i.rd_ev) chk("prdata", exp_q.pop_front(), oap_super_model_i.rd_val);
  // self-count kept inside its limits so no spurious error latches
  always @(posedge pclk) self_count <= 16'h0100 + 16'($random(seed) & 32'h7fff);
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      wrap_up();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 50158;
    presetn = 1'b0;
    {pn, ev, term_word_valid, diag_active, sig_a, sig_b, sig_c} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(OAP_PERIOD_OFS, 32'(OAP_PERIOD_RST));
    rd(8'h18, 32'h0);
    chk("pslverr", 1'b1, oap_super_model_i.rd_err);
    term_word_valid <= 1'b1;
    sk(1);
    chk("accept", 1'b1, term_word_accept);
    wr(OAP_ADDR_OFS, 32'h0000_2c5a);
    wr(OAP_CTRL_OFS, 32'h1 << OAP_CTRL_START);
    // the forced dump stands only in the cycle right after the start edge
    sk(0);
    chk("dump", 3'b111, {dump_pulse, delay_send, pf_check});
    sk(1);
    chk("super", 2'b10, {lamps.disp_super, term_word_accept});
    for (int k = 1; k < 7; k++) begin
      chk("phase", (k == 6) ? 0 : k, seq_phase);
      sk(4);
    end
    rd(OAP_STORED_OFS, 32'h0000_2c5a);
    // held past one whole dump interval so a pf_check pulse and a write phase both see them
    ev.left_fail <= 1'b1;
    ev.parity_ts <= 1'b1;
    sk(50);
    chk("err", 7'h44, lamps.err);
    @(posedge pclk);
    ev.left_fail <= 1'b0;
    ev.parity_ts <= 1'b0;
    pn.fr_left <= 1'b1;
    sk(2);
    chk("err", 7'h44, lamps.err);
    @(posedge pclk);
    pn.interlock <= 1'b1;
    sk(2);
    chk("err", 7'h04, lamps.err);
    @(posedge pclk);
    pn.interlock <= 1'b0;
    pn.fr_left <= 1'b0;
    wr(OAP_CTRL_OFS, 32'h1 << OAP_CTRL_START);
    sk(1);
    chk("err", 7'h00, lamps.err);
    @(posedge pclk);
    ev.overflow <= 1'b1;
    ev.term_err <= 1'b1;
    @(posedge pclk);
    ev.term_err <= 1'b0;
    pn.ind_reset <= 4'h8;
    sk(2);
    chk("err", 7'h09, lamps.err);
    chk("alarm", 2'b11, {buzzer, lamps.visual});
    @(posedge pclk);
    ev.overflow <= 1'b0;
    sk(2);
    chk("err", 7'h01, lamps.err);
    @(posedge pclk);
    pn.ind_reset <= 4'h0;
    pn.alarm_reset <= 1'b1;
    sk(2);
    chk("alarm", 2'b01, {buzzer, lamps.visual});
    for (int b = 0; b < 2; b++) begin
      @(posedge pclk);
      pn.alarm_reset <= 1'b0;
      pn.ind_reset <= 4'h0;
      oap_super_model_i.report_par(b);
      sk(3);
      chk("arch", 2'b11, {lamps.err.parity_arch, buzzer});
      @(posedge pclk);
      pn.ind_reset <= 4'h3;
      sk(2);
      chk("err", 7'h00, lamps.err);
    end
    @(posedge pclk);
    pn.ind_reset <= 4'h0;
    pn.fr_startup <= 1'b1;
    sk(2);
    chk("mreset", 2'b01, {master_reset, buzzer});
    @(posedge pclk);
    pn.interlock <= 1'b1;
    sk(1);
    chk("mreset", 2'b11, {master_reset, term_seq_reset});
    @(posedge pclk);
    pn <= '0;
    ev.osc_fail <= 1'b1;
    // start-up cleared everything; only the standby flag from the failure remains
    rd(OAP_STATUS_OFS, 32'h0000_0400);
    ev.osc_fail <= 1'b0;
    pn.fr_osc <= 1'b1;
    sk(2);
    chk("standby", 1'b1, lamps.osc_standby);
    @(posedge pclk);
    pn.interlock <= 1'b1;
    sk(2);
    chk("standby", 1'b0, lamps.osc_standby);
    chk("status", 2'b00, {lamps.disp_super, lamps.disp_test});
    @(posedge pclk);
    pn <= '0;
    wr(OAP_CTRL_OFS, 32'h1 << OAP_CTRL_TEST);
    sk(2);
    chk("status", 2'b01, {lamps.disp_super, lamps.disp_test});
    @(posedge pclk);
    pn.clock_sw_test <= 1'b1;
    wr(OAP_CTRL_OFS, 32'h1 << OAP_CTRL_START);
    sk(3);
    chk("clk_test", 2'b01, {lamps.disp_super, lamps.clock_test});
    @(posedge pclk);
    pn.clock_sw_test <= 1'b0;
    pn.local_test <= 1'b1;
    pn.disp_par_sw1 <= 1'b1;
    diag_active <= 1'b1;
    sk(2);
    chk("local", 5'h0b, {lamps.clock_test, lamps.visual, super_clk_en, par_disp_en,
      term_monitor & term_to_ctrl});
    @(posedge pclk);
    pn.local_test <= 1'b0;
    pn.monitor_override <= 1'b1;
    sk(2);
    chk("override", 2'b10, {lamps.visual, par_disp_en});
    @(posedge pclk);
    pn.ind_test <= 1'b1;
    sk(2);
    chk("lamps", {1'b1, oap_lamp_type'('1)}, {buzzer, lamps});
    @(posedge pclk);
    pn <= '0;
    for (int i = 0; i < 8; i++) begin
      c = 7'(($random(seed) & 32'hffff) % 80);
      wr(OAP_SEL_OFS, {17'h0, c, 1'b0, 3'(7 - i), 1'b0, 3'(i)});
      sig_a <= 8'($random(seed));
      sig_b <= 8'($random(seed));
      sig_c <= 80'({$random(seed), $random(seed), $random(seed)});
      sk(2);
      chk("tp", {sig_a[i], sig_b[7 - i], sig_c[c]}, {tp_a, tp_b, tp_c});
    end
    wrap_up();
  end
endmodule : oap_ctrl_tb
`default_nettype wire
